// >>> design/embs_sequencer.sv
// External memory bus sequencer with program counter.
// Assumes pins are synchronised here; the core supplies op requests on clk.
// What this block does
// - Six two-clock states make one cycle.
// - Opcode loaded S1, decoded S2, executed after.
// - Two-cycle instructions take 24 clocks.
// - Multiply and divide take 48 clocks.
// - Two address strobes per machine cycle.
// - Address strobe suppressed during data strobes.
// - Low address driven on port 0.
// - Fetch strobe only for external fetches.
// - Fetch strobe low-active, omitted during data strobes.
// - Write strobe low with accumulator on port 0.
// - Read strobe low, port 0 captured.
// - Program counter counts fetched bytes.
// - Counter wraps from ffff to 0000.
// - Internal fetch up to 3fff, external above.
// - ROMless variant fetches everything externally.
// - Pointer pair forms a 16-bit data address.
// - Address latched before data strobe asserts.
// - Index register gives an 8-bit address.
// - Port 2 latch stays during index access.
// - Strobes high while reset is applied.
`timescale 1ns/1ps
`default_nettype none
module embs_sequencer import embs_pkg::*; #(
	parameter bit HAS_INT_ROM = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic opStart,
	input wire logic [2:0] opCycles,
	input wire logic xmemReq,
	input wire logic xmemWrite,
	input wire logic usePointer,
	input wire logic [7:0] pointerLowByte,
	input wire logic [7:0] pointerHighByte,
	input wire logic [7:0] indexReg,
	input wire logic [7:0] port2Latch,
	input wire logic [7:0] accData,
	input wire logic [7:0] port0In,
	output logic [7:0] port0Out,
	output logic port0Oe,
	output logic [7:0] port2Out,
	output logic addrLatchStrobe,
	output logic program_fetch_strobe_n,
	output logic readStrobeN,
	output logic writeStrobeN,
	output logic [15:0] progCounter,
	output logic [7:0] opcodeHoldingReg,
	output logic [7:0] readData,
	output logic readValid,
	output logic decodeStrobe,
	output logic instrDone
);
	logic [3:0] phase;
	logic cycleEnd;
	logic [7:0] p0Sync1_r;
	logic [7:0] p0Sync2_r;
	logic [2:0] cycLeft_r;
	logic [2:0] cycIdx_r;
	logic dataCyc_r;
	logic dataWr_r;
	logic dataPtr_r;
	logic extFetch;
	logic [15:0] pcNxt;
	logic [5:0] instrClk_r;
	logic [2:0] instrLen_r;
	logic [3:0] strobeLow_r;

	embs_state_timer uTimer (
		.clk(clk),
		.rst_n(rst_n),
		.phase(phase),
		.cycleEnd(cycleEnd)
	);

	function automatic logic [15:0] pcInc(input logic [15:0] pc);
		pcInc = pc + 16'h0001;
	endfunction

	assign extFetch = !HAS_INT_ROM || (progCounter > EMBS_INT_ROM_TOP);
	assign pcNxt = pcInc(progCounter);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p0Sync1_r <= 8'h00;
			p0Sync2_r <= 8'h00;
		end else begin
			p0Sync1_r <= port0In;
			p0Sync2_r <= p0Sync1_r;
		end
	end

	// Instruction length bookkeeping in machine cycles.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cycLeft_r <= 3'h0;
			cycIdx_r <= 3'h0;
			instrDone <= 1'b0;
		end else begin
			instrDone <= 1'b0;
			if (cycleEnd) begin
				if (cycLeft_r > 3'h1) begin
					cycLeft_r <= cycLeft_r - 3'h1;
					cycIdx_r <= cycIdx_r + 3'h1;
				end else begin
					cycLeft_r <= 3'h0;
					cycIdx_r <= 3'h0;
					instrDone <= (cycLeft_r != 3'h0);
				end
			end
			if (phase == 4'h0 && opStart && cycLeft_r == 3'h0) begin
				cycLeft_r <= (opCycles == 3'h0) ? EMBS_CYC_ONE : opCycles;
			end
		end
	end

	// The external data cycle is the second machine cycle of a move op.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataCyc_r <= 1'b0;
			dataWr_r <= 1'b0;
			dataPtr_r <= 1'b0;
		end else if (phase == 4'h0 && opStart && xmemReq && cycLeft_r == 3'h0) begin
			dataWr_r <= xmemWrite;
			dataPtr_r <= usePointer;
		end else if (cycleEnd) begin
			dataCyc_r <= (cycLeft_r == EMBS_CYC_TWO) && xmemReq;
		end
	end

	// Opcode capture in S1 and decode pulse in S2.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			opcodeHoldingReg <= 8'h00;
			decodeStrobe <= 1'b0;
		end else begin
			decodeStrobe <= (phase == 4'h2) && (cycIdx_r == 3'h0);
			if (phase == 4'h1 && cycIdx_r == 3'h0) begin
				opcodeHoldingReg <= p0Sync2_r;
			end
		end
	end

	// Program counter: one byte per fetch slot (S1 and S4).
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			progCounter <= EMBS_PC_RESET;
		end else if ((phase == 4'h1 || phase == 4'h7) && !dataCyc_r && cycLeft_r != 3'h0) begin
			progCounter <= pcNxt;
		end
	end

	// Strobes: address strobe in S1 and S4, dropping the S4 one in a data cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addrLatchStrobe <= 1'b1;
			program_fetch_strobe_n <= 1'b1;
			readStrobeN <= 1'b1;
			writeStrobeN <= 1'b1;
		end else begin
			addrLatchStrobe <= (phase == 4'h0 || phase == 4'h6) && !(dataCyc_r && phase == 4'h6);
			program_fetch_strobe_n <= !(extFetch && !dataCyc_r &&
				((phase >= 4'h2 && phase <= 4'h4) || (phase >= 4'h8 && phase <= 4'ha)));
			readStrobeN <= !(dataCyc_r && !dataWr_r && phase >= 4'h2 && phase <= 4'h8);
			writeStrobeN <= !(dataCyc_r && dataWr_r && phase >= 4'h2 && phase <= 4'h8);
		end
	end

	// Port 0 and port 2 address/data multiplexing.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port0Out <= EMBS_PORT_RESET;
			port0Oe <= 1'b0;
			port2Out <= EMBS_PORT_RESET;
		end else if (dataCyc_r) begin
			port2Out <= dataPtr_r ? pointerHighByte : port2Latch;
			if (phase <= 4'h1 || phase == 4'hb) begin
				port0Out <= dataPtr_r ? pointerLowByte : indexReg;
				port0Oe <= 1'b1;
			end else if (dataWr_r) begin
				port0Out <= accData;
				port0Oe <= 1'b1;
			end else begin
				port0Oe <= 1'b0;
			end
		end else if (extFetch && (phase <= 4'h1 || (phase >= 4'h5 && phase <= 4'h7))) begin
			port0Out <= progCounter[7:0];
			port0Oe <= 1'b1;
			port2Out <= progCounter[15:8];
		end else begin
			port0Oe <= 1'b0;
		end
	end

	// Read data captured at the end of the read strobe.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readData <= 8'h00;
			readValid <= 1'b0;
		end else begin
			readValid <= 1'b0;
			if (dataCyc_r && !dataWr_r && phase == 4'h8) begin
				readData <= p0Sync2_r;
				readValid <= 1'b1;
			end
		end
	end

	// Clocks spent on the running instruction, kept for the length check.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instrClk_r <= 6'h00;
			instrLen_r <= 3'h0;
		end else if (phase == 4'h0 && opStart && cycLeft_r == 3'h0) begin
			instrClk_r <= 6'h01;
			instrLen_r <= (opCycles == 3'h0) ? EMBS_CYC_ONE : opCycles;
		end else if (cycLeft_r != 3'h0) begin
			instrClk_r <= instrClk_r + 6'h01;
		end
	end

	// Clocks for which a data strobe has stayed low, kept for the width check.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobeLow_r <= 4'h0;
		end else if (!readStrobeN || !writeStrobeN) begin
			strobeLow_r <= strobeLow_r + 4'h1;
		end else begin
			strobeLow_r <= 4'h0;
		end
	end

	// Steps of a data cycle: address out with the strobe, address held, then a data strobe.
	sequence addrOnBus_s;
		addrLatchStrobe && port0Oe && port0Out == (dataPtr_r ? pointerLowByte : indexReg);
	endsequence
	sequence addrHeld_s;
		!addrLatchStrobe && port0Oe;
	endsequence
	sequence dataStrobe_s;
		!readStrobeN || !writeStrobeN;
	endsequence
	sequence fetchLow_s;
		!program_fetch_strobe_n;
	endsequence

	// Address strobe and address bus.
	ale_second_a: assert property (@(posedge clk) disable iff (!rst_n)
		(phase == 4'h6 && !dataCyc_r) |=> addrLatchStrobe)
		else $error("Address strobe missing in S4.");
	ale_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		(phase == 4'h6 && dataCyc_r) |=> !addrLatchStrobe)
		else $error("Address strobe in S4 of a data cycle.");
	ale_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
		(addrLatchStrobe && $past(rst_n)) |-> (phase == 4'h1 || phase == 4'h7))
		else $error("Address strobe outside S1 and S4.");
	addr_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		(dataCyc_r && phase == 4'h1) |-> addrOnBus_s ##1 addrHeld_s ##1 dataStrobe_s)
		else $error("Data address not latched before the strobe.");
	port2_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(dataCyc_r && phase == 4'h3) |-> port2Out == (dataPtr_r ? pointerHighByte : port2Latch))
		else $error("Wrong high address on port 2.");
	fetch_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(extFetch && !dataCyc_r && phase == 4'h0) |=> port0Oe && port0Out == $past(progCounter[7:0]) &&
		port2Out == $past(progCounter[15:8]))
		else $error("Fetch address not on the ports.");
	idle_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!dataCyc_r && !extFetch) |=> !port0Oe)
		else $error("Port 0 driven for an internal fetch.");

	// Fetch and data strobes.
	fetch_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		(phase == 4'h2 && extFetch && !dataCyc_r) |=> fetchLow_s [*3] ##1 program_fetch_strobe_n)
		else $error("First fetch pulse wrong.");
	fetch_second_a: assert property (@(posedge clk) disable iff (!rst_n)
		(phase == 4'h8 && extFetch && !dataCyc_r) |=> fetchLow_s [*3] ##1 program_fetch_strobe_n)
		else $error("Second fetch pulse wrong.");
	rd_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		(dataCyc_r && !dataWr_r && phase == 4'h2) |=> !port0Oe && !readStrobeN)
		else $error("Port 0 not released at the read strobe.");
	wr_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
		(dataCyc_r && dataWr_r && phase == 4'h2) |=> !writeStrobeN && readStrobeN)
		else $error("Write strobe missing.");
	rd_wr_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
		!readStrobeN |-> writeStrobeN)
		else $error("Read and write strobes together.");
	no_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
		!dataCyc_r |-> readStrobeN && writeStrobeN)
		else $error("Data strobe outside a data cycle.");
	rd_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
		(dataCyc_r && !dataWr_r && phase == 4'h8) |=> readValid && readData == $past(p0Sync2_r))
		else $error("Read data not captured.");
	strobe_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(readStrobeN && writeStrobeN) |-> strobeLow_r == EMBS_STROBE_CLKS)
		else $error("Data strobe width wrong.");
	rst_strobe_a: assert property (@(posedge clk)
		(!rst_n ##1 !rst_n) |-> addrLatchStrobe && program_fetch_strobe_n && readStrobeN && writeStrobeN)
		else $error("Strobes not high in reset.");

	// Instruction timing and program counter.
	instr_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		instrDone |-> instrClk_r == 6'(int'(instrLen_r) * EMBS_CLK_PER_CYCLE))
		else $error("Instruction length wrong.");
	instr_done_a: assert property (@(posedge clk) disable iff (!rst_n)
		instrDone |-> $past(cycleEnd))
		else $error("Instruction end off the cycle boundary.");
	decode_s2_a: assert property (@(posedge clk) disable iff (!rst_n)
		(phase == 4'h2 && cycIdx_r == 3'h0) |=> decodeStrobe)
		else $error("Decode pulse missing in S2.");
	opcode_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		(phase == 4'h1 && cycIdx_r == 3'h0) |=> opcodeHoldingReg == $past(p0Sync2_r))
		else $error("Opcode not loaded in S1.");
	pc_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cycLeft_r == 3'h0) |=> $stable(progCounter))
		else $error("Counter moved with no instruction.");

	// Strobe exclusion, counter and cycle checks.
	ale_twice_a: assert property (@(posedge clk) disable iff (!rst_n)
		(phase == 4'h0 && !dataCyc_r) |=> addrLatchStrobe)
		else $error("Address strobe missing in S1.");
	ale_supp_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!readStrobeN || !writeStrobeN) |-> !addrLatchStrobe)
		else $error("Address strobe during data strobe.");
	fetch_supp_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!readStrobeN || !writeStrobeN) |-> program_fetch_strobe_n)
		else $error("Fetch strobe during data strobe.");
	fetch_int_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(!extFetch) && $stable(progCounter) |-> program_fetch_strobe_n)
		else $error("Fetch strobe for internal fetch.");
	pc_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		(progCounter == 16'hffff) ##1 $changed(progCounter) |-> progCounter == 16'h0000)
		else $error("Counter did not wrap.");
	pc_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(progCounter) |-> progCounter == $past(progCounter) + 16'h0001)
		else $error("Counter step not one.");
	rd_float_a: assert property (@(posedge clk) disable iff (!rst_n)
		!readStrobeN |-> !port0Oe)
		else $error("Port 0 driven during read.");
	wr_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		!writeStrobeN |-> port0Oe && port0Out == $past(accData))
		else $error("Write data not on port 0.");
	cyc_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		cycleEnd |=> phase == 4'h0 ##11 cycleEnd)
		else $error("Machine cycle not twelve clocks.");
endmodule
`default_nettype wire

// >>> design/embs_pkg.sv
// Constants shared by the external memory bus sequencer.
// Assumes a single 100 MHz clock that stands in for the oscillator.
package embs_pkg;
	localparam int EMBS_CLK_PER_STATE = 2;
	localparam int EMBS_STATES = 6;
	localparam int EMBS_CLK_PER_CYCLE = EMBS_CLK_PER_STATE * EMBS_STATES;
	localparam logic [15:0] EMBS_PC_RESET = 16'h0000;
	localparam logic [15:0] EMBS_INT_ROM_TOP = 16'h3fff;
	localparam logic [7:0] EMBS_PORT_RESET = 8'hff;
	localparam logic [2:0] EMBS_CYC_ONE = 3'h1;
	localparam logic [2:0] EMBS_CYC_TWO = 3'h2;
	localparam logic [2:0] EMBS_CYC_FOUR = 3'h4;
	localparam logic [3:0] EMBS_PHASE_LAST = 4'hb;
	localparam logic [3:0] EMBS_STROBE_CLKS = 4'h7;
	typedef enum logic [1:0] {EMBS_OP_FETCH, EMBS_OP_XRD, EMBS_OP_XWR} embs_op_t;
endpackage

// >>> design/embs_state_timer.sv
// State timer: counts oscillator clocks into states S1..S6.
// Assumes the same clock and reset as the sequencer.
`timescale 1ns/1ps
`default_nettype none
module embs_state_timer import embs_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	output logic [3:0] phase,
	output logic cycleEnd
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 4'h0;
		end else if (phase == EMBS_PHASE_LAST) begin
			phase <= 4'h0;
		end else begin
			phase <= phase + 4'h1;
		end
	end
	assign cycleEnd = (phase == EMBS_PHASE_LAST);
endmodule
`default_nettype wire

// >>> tb/embs_ext_mem.sv
// Partner model: external address latch, program memory and data memory.
// Assumes the sequencer's strobes and port levels on one clock.
`timescale 1ns/1ps
`default_nettype none
module embs_ext_mem (
	input wire logic clk,
	input wire logic addrLatchStrobe,
	input wire logic [7:0] port0Out,
	input wire logic port0Oe,
	input wire logic [7:0] port2Out,
	input wire logic readStrobeN,
	input wire logic writeStrobeN,
	input wire logic program_fetch_strobe_n,
	output logic [7:0] port0In,
	output logic [15:0] lastAddr
);
	logic [7:0] ram [0:65535];
	logic [7:0] lowAddr = 8'h00;
	logic [7:0] prevP0 = 8'h00;
	assign lastAddr = {port2Out, lowAddr};
	always @(negedge addrLatchStrobe) begin
		lowAddr = port0Out;
	end
	always @(posedge clk) begin
		prevP0 <= port0In;
		if (!writeStrobeN && port0Oe) begin
			ram[lastAddr] <= port0Out;
		end
	end
	always @* begin
		if (!readStrobeN) begin
			port0In = ram[lastAddr];
		end else if (!program_fetch_strobe_n) begin
			port0In = lowAddr ^ port2Out;
		end else begin
			port0In = ~prevP0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Testbench of the sequencer against a bench model and the memory partner.
// Assumes a 100 MHz clock and the ROMless variant.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import embs_pkg::*;
	logic clk = 0, rst_n = 0, opStart = 0, xmemReq = 0, xmemWrite = 0, usePointer = 0;
	logic [2:0] opCycles = 3'h1;
	logic [7:0] ptrLo = 0, ptrHi = 0, idx = 0, p2 = 0, acc = 0, port0In, port0Out, port2Out, readData;
	logic port0Oe, ale, fetchN, rdN, wrN, readValid, instrDone;
	logic [15:0] pc, lastAddr, addr;
	logic [7:0] expMem [logic [15:0]];
	int fails = 0, samples_checked = 0;
	int unsigned rng = 89;
	embs_sequencer #(.HAS_INT_ROM(1'b0)) u_dut (.clk(clk), .rst_n(rst_n), .opStart(opStart),
		.opCycles(opCycles), .xmemReq(xmemReq), .xmemWrite(xmemWrite), .usePointer(usePointer),
		.pointerLowByte(ptrLo), .pointerHighByte(ptrHi), .indexReg(idx), .port2Latch(p2), .accData(acc),
		.port0In(port0In), .port0Out(port0Out), .port0Oe(port0Oe), .port2Out(port2Out),
		.addrLatchStrobe(ale), .program_fetch_strobe_n(fetchN), .readStrobeN(rdN), .writeStrobeN(wrN),
		.progCounter(pc), .opcodeHoldingReg(), .readData(readData), .readValid(readValid),
		.decodeStrobe(), .instrDone(instrDone));
	embs_ext_mem u_mem (.clk(clk), .addrLatchStrobe(ale), .port0Out(port0Out), .port0Oe(port0Oe),
		.port2Out(port2Out), .readStrobeN(rdN), .writeStrobeN(wrN), .program_fetch_strobe_n(fetchN),
		.port0In(port0In), .lastAddr(lastAddr));
	initial forever #5 clk = ~clk;
	function automatic logic [7:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Runs two identical instructions back to back and measures the second.
	task automatic runOp(input int cyc, input bit xr, input bit wr, input bit ptr);
		int clks, ales, fetches, dones, guard;
		logic lastAle, lastFetch;
		@(negedge clk);
		if (!xr || wr) begin
			ptrLo = xs(); ptrHi = xs(); idx = xs(); p2 = xs(); acc = xs();
		end
		opCycles = cyc[2:0]; xmemReq = xr; xmemWrite = wr; usePointer = ptr; opStart = 1;
		addr = ptr ? {ptrHi, ptrLo} : {p2, idx};
		if (xr && wr) expMem[addr] = acc;
		clks = 0; ales = 0; fetches = 0; dones = 0; lastAle = 1; lastFetch = 1;
		for (guard = 0; guard < 400 && dones < 2; guard++) begin
			@(posedge clk); #1;
			if (dones == 1) begin
				clks++;
				if (ale && !lastAle) ales++;
				if (!fetchN && lastFetch) fetches++;
			end
			lastAle = ale; lastFetch = fetchN;
			if (port0Oe === 1'b1 && rdN === 1'b0) check(1, 0);
			if (fetchN === 1'b0 && (rdN === 1'b0 || wrN === 1'b0)) check(1, 0);
			if (readValid === 1'b1) begin
				check(readData, expMem[addr]);
				check(lastAddr, addr);
			end
			if (instrDone === 1'b1) dones++;
		end
		@(negedge clk) opStart = 0;
		if (guard >= 400) begin
			fails++;
			results();
		end
		check(clks, cyc * 12);
		check(ales, 2 * cyc - xr);
		if (!xr) check(fetches, 2 * cyc);
	endtask
	initial begin
		@(posedge clk); #1;
		check({ale, fetchN, rdN, wrN, port0Oe}, 5'h1e);
		check(pc, EMBS_PC_RESET);
		repeat (2) @(posedge clk);
		@(negedge clk) rst_n = 1;
		runOp(1, 0, 0, 0);
		runOp(2, 0, 0, 0);
		runOp(4, 0, 0, 0);
		for (int p = 0; p < 2; p++) begin
			runOp(2, 1, 1, p[0]);
			runOp(2, 1, 0, p[0]);
		end
		@(negedge clk) rst_n = 0;
		#1 check({ale, fetchN, rdN, wrN, port0Oe}, 5'h1e);
		check(pc, EMBS_PC_RESET);
		repeat (3) @(negedge clk);
		rst_n = 1;
		runOp(2, 1, 0, 1);
		results();
	end
endmodule
`default_nettype wire
